/* File: verilog/power_state_sequencer.v */
// Purpose: power control state machine for coin-cell, off and cold-start
// Assumes: clk_in at 250 MHz; osc_tick_in is the 32 kHz oscillator edge pulse
// Notes: later states are tracked only as far as port gating needs
//   reset pins are open-drain; an oe high pulls the pin low
//   user-off-wait is kept as a flag inside the on state
//
// What this block does
// - serial control accepted only in watchdog, on and user-off-wait states
// - interrupt line held low outside watchdog and on states
// - coin-cell state ignores every turn-on event
// - coin-cell exits to off only when always-on supply is above threshold
// - coin-cell state drives both reset outputs low
// - coin-cell depletion in coin-cell state resets all control logic
// - after depletion every control bit returns to default, rtc-reset ones too
// - off state left for cold start only on a valid turn-on event, for coin-cell on supply loss
// - no state timer runs in the off state
// - off state drives both reset outputs low
// - turn-on events rejected in off while supply is under threshold
// - cold start from off turn-on, warm boot, power-cut recovery, silent restart
// - cold start begins with init interval latching mode pins, qualifying supply
// - regulators then enabled one by one, never all together
// - reset timer starts on cold start entry; resets stay low while it runs
// - timer expiry moves to watchdog state and releases both open-drain resets
// - watchdog and standby inputs ignored during cold start
// - default start-up configuration taken from mode select pins
// - each input-configured general pin can raise an external interrupt
// - watchdog state runs its timer, ignores inputs, then moves to on
// - in on, keepalive low moves to off or cold start per configuration, unless the user-off-wait flag is set
`include "power_state_sequencer_consts.vh"

module power_state_sequencer #(
  parameter NUM_REGS = `PSS_NUM_REGS,
  parameter TW = `PSS_TIMER_W,
  parameter [TW-1:0] INIT_TICKS = `PSS_INIT_TICKS,
  parameter [TW-1:0] RESET_TICKS = `PSS_RESET_TICKS,
  parameter [TW-1:0] WDOG_TICKS = `PSS_WDOG_TICKS,
  parameter [TW-1:0] SLOT_TICKS = `PSS_SLOT_TICKS
) (
  // clock and reset
  input wire clk_in,
  input wire sys_rst_in,
  input wire osc_tick_in,
  // supply and coin-cell status
  input wire always_on_supply_ok_in,
  input wire coin_cell_depleted_in,
  input wire input_supply_node_ok_in,
  // turn-on sources
  input wire turn_on_event_in,
  input wire warm_boot_in,
  input wire supply_dropout_event_in,
  input wire silent_restart_in,
  input wire user_off_request_in,
  input wire wdi_restart_enable_in,
  // processor side pins
  input wire watchdog_keepalive_in,
  input wire standby_in,
  input wire [`PSS_POWERUP_MODE_SELECT_PINS_W-1:0] powerup_mode_select_pins,
  input wire [`PSS_GPIO_W-1:0] gpio_pins_in,
  input wire [`PSS_GPIO_W-1:0] gpio_is_input_in,
  // serial control gating
  input wire serial_access_in,
  output reg serial_access_ok_out,
  // reset outputs, open-drain
  output reg system_reset_out_n,
  output reg system_reset_oe_out,
  output reg processor_reset_out_n,
  output reg processor_reset_oe_out,
  // interrupt and regulators
  output reg int_out,
  output reg [`PSS_GPIO_W-1:0] gpio_event_out,
  output reg [NUM_REGS-1:0] regulator_enable_out,
  output reg [`PSS_POWERUP_MODE_SELECT_PINS_W-1:0] latched_mode_out,
  output reg [4:0] power_state_out
);
  localparam [4:0] ST_COIN = 5'h01;
  localparam [4:0] ST_OFF = 5'h02;
  localparam [4:0] ST_COLD = 5'h04;
  localparam [4:0] ST_WDOG = 5'h08;
  localparam [4:0] ST_ON = 5'h10;
  localparam [1:0] PH_INIT = 2'h1;
  localparam [1:0] PH_SEQ = 2'h2;

  reg [4:0] state;
  reg [4:0] next_state;
  reg [1:0] phase;
  reg [NUM_REGS-1:0] reg_mask;
  reg wait_state;
  reg [`PSS_GPIO_W-1:0] gpio_prev;
  wire full_rst;
  wire keepalive_s;
  wire standby_s;
  wire [`PSS_POWERUP_MODE_SELECT_PINS_W-1:0] powerup_mode_select_pins_s;
  wire [`PSS_GPIO_W-1:0] gpio_s;
  wire init_done;
  wire slot_done;
  wire rst_done;
  wire wd_done;
  wire entering_cold;
  wire entering_wdog;
  wire off_turn_on;
  wire restart_req;
  wire cold_req;
  wire run_state;

  // depletion in coin-cell state acts as a full reset of all control bits
  assign full_rst = sys_rst_in | (state == ST_COIN && coin_cell_depleted_in);

  pin_sync #(.WIDTH(1), .INIT(1'b1)) u_sync_wdi (
    .clk_in(clk_in),
    .sys_rst_in(full_rst),
    .async_in(watchdog_keepalive_in),
    .sync_out(keepalive_s)
  );

  pin_sync #(.WIDTH(1), .INIT(1'b0)) u_sync_stby (
    .clk_in(clk_in),
    .sys_rst_in(full_rst),
    .async_in(standby_in),
    .sync_out(standby_s)
  );

  pin_sync #(.WIDTH(`PSS_POWERUP_MODE_SELECT_PINS_W), .INIT({`PSS_POWERUP_MODE_SELECT_PINS_W{1'b0}})) u_sync_powerup_mode_select_pins (
    .clk_in(clk_in),
    .sys_rst_in(full_rst),
    .async_in(powerup_mode_select_pins),
    .sync_out(powerup_mode_select_pins_s)
  );

  pin_sync #(.WIDTH(`PSS_GPIO_W), .INIT({`PSS_GPIO_W{1'b0}})) u_sync_gpio (
    .clk_in(clk_in),
    .sys_rst_in(full_rst),
    .async_in(gpio_pins_in),
    .sync_out(gpio_s)
  );

  // off is left for cold start only on a qualified turn-on event
  assign off_turn_on = state == ST_OFF && turn_on_event_in && always_on_supply_ok_in;
  // the on state restarts through cold start
  assign restart_req = (state == ST_ON)
    && (warm_boot_in || supply_dropout_event_in || silent_restart_in);
  assign cold_req = off_turn_on || restart_req;

  assign entering_cold = (next_state == ST_COLD) && (state != ST_COLD);
  assign entering_wdog = (next_state == ST_WDOG) && (state != ST_WDOG);
  // reset pins released only once running
  assign run_state = next_state == ST_WDOG || next_state == ST_ON;

  // init interval, counted in oscillator ticks
  tick_timer #(.WIDTH(TW)) u_init_timer (
    .clk_in(clk_in),
    .sys_rst_in(full_rst),
    .load_in(entering_cold),
    .length_in(INIT_TICKS),
    .run_in(state == ST_COLD && phase == PH_INIT),
    .tick_in(osc_tick_in),
    .done_out(init_done),
    .busy_out()
  );

  // regulator time slot spacing
  tick_timer #(.WIDTH(TW)) u_slot_timer (
    .clk_in(clk_in),
    .sys_rst_in(full_rst),
    .load_in(init_done | slot_done),
    .length_in(SLOT_TICKS),
    .run_in(state == ST_COLD && phase == PH_SEQ && !(&reg_mask)),
    .tick_in(osc_tick_in),
    .done_out(slot_done),
    .busy_out()
  );

  // reset timer, runs from cold start entry
  tick_timer #(.WIDTH(TW)) u_reset_timer (
    .clk_in(clk_in),
    .sys_rst_in(full_rst),
    .load_in(entering_cold),
    .length_in(RESET_TICKS),
    .run_in(state == ST_COLD),
    .tick_in(osc_tick_in),
    .done_out(rst_done),
    .busy_out()
  );

  // watchdog timer, runs from watchdog state entry
  tick_timer #(.WIDTH(TW)) u_wdog_timer (
    .clk_in(clk_in),
    .sys_rst_in(full_rst),
    .load_in(entering_wdog),
    .length_in(WDOG_TICKS),
    .run_in(state == ST_WDOG),
    .tick_in(osc_tick_in),
    .done_out(wd_done),
    .busy_out()
  );

  always @* begin
    next_state = state;
    case (state)
      ST_COIN: begin
        // turn-on events not looked at here
        if (always_on_supply_ok_in) begin
          next_state = ST_OFF;
        end
      end
      ST_OFF: begin
        // no timer runs here
        if (!always_on_supply_ok_in) begin
          next_state = ST_COIN;
        end else if (cold_req) begin
          next_state = ST_COLD;
        end
      end
      ST_COLD: begin
        // keepalive and standby not looked at here
        if (!always_on_supply_ok_in) begin
          next_state = ST_COIN;
        end else if (rst_done) begin
          next_state = ST_WDOG;
        end
      end
      ST_WDOG: begin
        // keepalive and standby not looked at here
        if (wd_done) begin
          next_state = ST_ON;
        end
      end
      ST_ON: begin
        if (cold_req) begin
          next_state = ST_COLD;
        end else if (!keepalive_s && !wait_state) begin
          next_state = wdi_restart_enable_in ? ST_COLD : ST_OFF;
        end
      end
      default: begin
        next_state = ST_COIN;
      end
    endcase
  end

  always @(posedge clk_in) begin
    if (full_rst) begin
      state <= ST_COIN;
      phase <= PH_INIT;
      reg_mask <= {NUM_REGS{1'b0}};
      wait_state <= 1'b0;
      latched_mode_out <= {`PSS_POWERUP_MODE_SELECT_PINS_W{1'b0}};
    end else begin
      state <= next_state;
      if (entering_cold) begin
        phase <= PH_INIT;
        reg_mask <= {NUM_REGS{1'b0}};
      end else if (init_done) begin
        // configuration taken from mode pins, supply qualified
        latched_mode_out <= powerup_mode_select_pins_s;
        phase <= input_supply_node_ok_in ? PH_SEQ : PH_INIT;
        reg_mask <= {{(NUM_REGS-1){1'b0}}, input_supply_node_ok_in};
      end else if (slot_done) begin
        reg_mask <= {reg_mask[NUM_REGS-2:0], 1'b1};
      end else if (next_state == ST_OFF || next_state == ST_COIN) begin
        reg_mask <= {NUM_REGS{1'b0}};
      end
      if (state == ST_ON && user_off_request_in) begin
        wait_state <= 1'b1;
      end else if (state != ST_ON) begin
        wait_state <= 1'b0;
      end
    end
  end

  always @(posedge clk_in) begin
    if (full_rst) begin
      system_reset_out_n <= 1'b0;
      system_reset_oe_out <= 1'b1;
      processor_reset_out_n <= 1'b0;
      processor_reset_oe_out <= 1'b1;
      int_out <= 1'b0;
      serial_access_ok_out <= 1'b0;
      gpio_event_out <= {`PSS_GPIO_W{1'b0}};
      gpio_prev <= {`PSS_GPIO_W{1'b0}};
      regulator_enable_out <= {NUM_REGS{1'b0}};
      power_state_out <= ST_COIN;
    end else begin
      power_state_out <= next_state;
      // resets low in coin-cell, off and cold start, released after
      system_reset_oe_out <= !run_state;
      processor_reset_oe_out <= !run_state;
      system_reset_out_n <= 1'b0;
      processor_reset_out_n <= 1'b0;
      // interrupt driven low except in watchdog and on
      int_out <= run_state && (|gpio_event_out);
      // user-off-wait lives inside on, so it is open too
      serial_access_ok_out <= serial_access_in
        && (state == ST_WDOG || (state == ST_ON));
      // edges only from pins set up as inputs
      gpio_prev <= gpio_s;
      gpio_event_out <= gpio_is_input_in & (gpio_s ^ gpio_prev);
      // regulators dark in coin-cell and off
      regulator_enable_out <= (next_state == ST_COLD || run_state)
        ? reg_mask : {NUM_REGS{1'b0}};
    end
  end
endmodule

/* File: verilog/power_state_sequencer_consts.vh */
// Purpose: shared constants of the power state sequencer
// Assumes: 250 MHz system clock, 32.768 kHz oscillator tick input
// Notes: definitions only
`ifndef POWER_STATE_SEQUENCER_CONSTS_VH
`define POWER_STATE_SEQUENCER_CONSTS_VH

// init interval: 8.0 ms of the 32768 Hz oscillator, rounded up
`define PSS_INIT_TICKS 16'h0107
// default lengths in oscillator ticks
`define PSS_RESET_TICKS 16'h0800
`define PSS_WDOG_TICKS 16'h0800
`define PSS_SLOT_TICKS 16'h0040
`define PSS_NUM_REGS 4
`define PSS_POWERUP_MODE_SELECT_PINS_W 2
`define PSS_GPIO_W 4
`define PSS_TIMER_W 16
`define PSS_SYNC_STAGES 3

`endif

/* File: verilog/pin_sync.v */
// Purpose: three-stage synchroniser with agreement qualification, per bit
// Assumes: async inputs from pins
// Notes: output changes once stages two and three agree
module pin_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
  // clock and reset
  input wire clk_in,
  input wire sys_rst_in,
  // pins
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] stage1;
  reg [WIDTH-1:0] stage2;
  reg [WIDTH-1:0] stage3;
  genvar i;

  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      stage1 <= INIT;
      stage2 <= INIT;
      stage3 <= INIT;
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always @(posedge clk_in) begin
        if (sys_rst_in) begin
          sync_out[i] <= INIT[i];
        end else if (stage2[i] == stage3[i]) begin
          sync_out[i] <= stage3[i];
        end
      end
    end
  endgenerate
endmodule

/* File: verilog/tick_timer.v */
// Purpose: down counter advanced by oscillator ticks
// Assumes: tick is a one-cycle pulse on clk_in
// Notes: load restarts; done pulses once when the count hits zero
module tick_timer #(
  parameter WIDTH = 16
) (
  // clock and reset
  input wire clk_in,
  input wire sys_rst_in,
  // control
  input wire load_in,
  input wire [WIDTH-1:0] length_in,
  input wire run_in,
  input wire tick_in,
  // status
  output reg done_out,
  output reg busy_out
);
  reg [WIDTH-1:0] count;

  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      count <= {WIDTH{1'b0}};
      done_out <= 1'b0;
      busy_out <= 1'b0;
    end else if (load_in) begin
      count <= length_in;
      done_out <= 1'b0;
      busy_out <= 1'b1;
    end else if (!run_in) begin
      busy_out <= 1'b0;
      done_out <= 1'b0;
    end else if (busy_out && tick_in) begin
      if (count <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
        count <= {WIDTH{1'b0}};
        done_out <= 1'b1;
        busy_out <= 1'b0;
      end else begin
        count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
        done_out <= 1'b0;
      end
    end else begin
      done_out <= 1'b0;
    end
  end
endmodule

/* File: bench/power_state_sequencer_chk.sv */
// Purpose: port assertions for the power state sequencer
// Assumes: one clock domain, synchronous active-high reset
// Notes: bound into every sequencer instance
module power_state_sequencer_chk #(
  parameter NUM_REGS = 4
) (
  // clock and reset
  input wire clk_in,
  input wire sys_rst_in,
  // watched inputs
  input wire always_on_supply_ok_in,
  input wire turn_on_event_in,
  input wire warm_boot_in,
  input wire supply_dropout_event_in,
  input wire silent_restart_in,
  // watched outputs
  input wire serial_access_ok_out,
  input wire system_reset_oe_out,
  input wire processor_reset_oe_out,
  input wire int_out,
  input wire [NUM_REGS-1:0] regulator_enable_out,
  input wire [4:0] power_state_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  wire [4:0] ps = power_state_out;
  wire closed = |ps[2:0];
  wire pulled = system_reset_oe_out && processor_reset_oe_out;
  wire rq = turn_on_event_in;
  wire restart_rq = warm_boot_in | supply_dropout_event_in | silent_restart_in;
  AST_SERIAL_GATE: assert property (serial_access_ok_out |-> !$past(closed))
    else $error("serial access accepted in a closed state");
  AST_INT_LOW: assert property (closed && $past(closed) |-> !int_out)
    else $error("interrupt raised in a closed state");
  AST_COIN_EXIT: assert property (
    $past(ps) == 5'h01 && ps != 5'h01 |-> ps == 5'h02 && $past(always_on_supply_ok_in))
    else $error("coin-cell state left wrongly");
  AST_COIN_RST: assert property (ps == 5'h01 |-> pulled)
    else $error("resets released in coin-cell state");
  AST_OFF_EXIT: assert property ($past(ps) == 5'h02 && ps != 5'h02 |->
    ps == 5'h01 || (ps == 5'h04 && $past(rq) && $past(always_on_supply_ok_in)))
    else $error("off state left without a valid turn-on");
  AST_OFF_RST: assert property (ps == 5'h02 |-> pulled)
    else $error("resets released in off state");
  AST_REG_STEP: assert property (
    $countones(regulator_enable_out) <= $countones($past(regulator_enable_out)) + 1)
    else $error("regulators enabled together");
  AST_COLD_RST: assert property (ps == 5'h04 |-> pulled)
    else $error("resets released during cold start");
  AST_RUN_REL: assert property (
    ps[3] || ps[4] |-> !system_reset_oe_out && !processor_reset_oe_out)
    else $error("resets still pulled after cold start");
  AST_ON_COLD: assert property ($past(ps) == 5'h10 && $past(restart_rq) |-> ps == 5'h04)
    else $error("restart request did not enter cold start");
  AST_COLD_EXIT: assert property ($past(ps) == 5'h04 |-> |(ps & 5'h0D))
    else $error("cold start left for a wrong state");
  cover property (ps == 5'h10);
  cover property ($past(ps) == 5'h04 && ps == 5'h08);
  cover property (serial_access_ok_out);
  cover property ($past(ps) == 5'h10 && ps == 5'h04);
endmodule

bind power_state_sequencer power_state_sequencer_chk #(.NUM_REGS(NUM_REGS)) i_chk (
  .clk_in, .sys_rst_in, .always_on_supply_ok_in, .turn_on_event_in, .warm_boot_in,
  .supply_dropout_event_in, .silent_restart_in, .serial_access_ok_out, .system_reset_oe_out,
  .processor_reset_oe_out, .int_out, .regulator_enable_out, .power_state_out);

/* File: bench/proc_model.sv */
// Purpose: processor on the far side of the reset and keepalive pins
// Assumes: resets are open-drain with pull-ups
// Notes: keepalive drops when the bench asks or while either reset is pulled
module proc_model (
  input wire clk_in,
  input wire sys_oe_in,
  input wire mcu_oe_in,
  input wire drop_in,
  output logic keepalive_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // pull-ups win when nobody pulls low
  wire sys_n = !sys_oe_in;
  wire mcu_n = !mcu_oe_in;
  initial keepalive_out = 1'b0;
  always @(posedge clk_in) begin
    keepalive_out <= sys_n && mcu_n && !drop_in;
  end
endmodule

/* File: bench/tb_power_state_sequencer.sv */
// Purpose: self-checking bench of the power state sequencer
// Assumes: 250 MHz clock, oscillator tick every 4 cycles
// Notes: timer lengths shortened for simulation
module tb_power_state_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 0, sys_rst_in = 1, osc_tick_in = 0, always_on_supply_ok_in = 0;
  logic coin_cell_depleted_in = 0, turn_on_event_in = 0, wdi_restart_enable_in = 0;
  logic standby_in = 0, serial_access_in = 0, drop = 0;
  logic input_supply_node_ok_in = 1, warm_boot_in = 0, user_off_request_in = 0;
  logic supply_dropout_event_in = 0, silent_restart_in = 0;
  logic [1:0] powerup_mode_select_pins = 2'h2, tc = 2'h0;
  logic [3:0] gpio_pins_in = 4'h0, gpio_is_input_in = 4'h0;
  wire watchdog_keepalive_in, serial_access_ok_out, system_reset_oe_out;
  wire processor_reset_oe_out, int_out;
  wire [3:0] gpio_event_out, regulator_enable_out;
  wire [1:0] latched_mode_out;
  wire [4:0] power_state_out;
  integer errors = 0, n_tests = 0, seed = 32'h4D87, i, j;
  initial forever #2 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    tc <= tc + 2'h1;
    osc_tick_in <= (tc == 2'h3);
    serial_access_in <= 1'($random(seed));
    standby_in <= 1'($random(seed));
    gpio_pins_in <= 4'($random(seed));
    gpio_is_input_in <= 4'($random(seed));
  end
  power_state_sequencer #(.INIT_TICKS(16'h0004), .RESET_TICKS(16'h0010),
    .WDOG_TICKS(16'h0008), .SLOT_TICKS(16'h0002)) i_dut (
    .clk_in, .sys_rst_in, .osc_tick_in, .always_on_supply_ok_in, .coin_cell_depleted_in,
    .input_supply_node_ok_in, .turn_on_event_in, .warm_boot_in,
    .supply_dropout_event_in, .silent_restart_in, .user_off_request_in,
    .wdi_restart_enable_in, .watchdog_keepalive_in, .standby_in, .powerup_mode_select_pins,
    .gpio_pins_in, .gpio_is_input_in, .serial_access_in, .serial_access_ok_out,
    .system_reset_out_n(), .system_reset_oe_out, .processor_reset_out_n(),
    .processor_reset_oe_out, .int_out, .gpio_event_out, .regulator_enable_out,
    .latched_mode_out, .power_state_out);
  proc_model i_proc (.clk_in, .sys_oe_in(system_reset_oe_out),
    .mcu_oe_in(processor_reset_oe_out), .drop_in(drop), .keepalive_out(watchdog_keepalive_in));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task cy(input integer n);
    repeat (n) @(posedge clk_in);
  endtask
  // bounded wait for a power state
  task wt(input logic [4:0] s);
    for (i = 0; i < 600 && power_state_out !== s; i++) cy(1);
    if (i == 600) begin
      errors++;
      report_and_stop;
    end
  endtask
  task pulse_on;
    turn_on_event_in <= 1'b1;
    cy(1);
    turn_on_event_in <= 1'b0;
  endtask
  // one-cycle restart request from the on state
  task restart(input integer k);
    warm_boot_in <= (k == 0);
    supply_dropout_event_in <= (k == 1);
    silent_restart_in <= (k == 2);
    cy(1);
    warm_boot_in <= 1'b0;
    supply_dropout_event_in <= 1'b0;
    silent_restart_in <= 1'b0;
    cy(1);
    chk(power_state_out, 5'h04);
  endtask
  initial begin
    cy(4);
    sys_rst_in <= 1'b0;
    turn_on_event_in <= 1'b1;
    cy(12);
    chk(power_state_out, 5'h01);
    chk({system_reset_oe_out, processor_reset_oe_out}, 2'h3);
    chk(serial_access_ok_out, 1'b0);
    $display("coin test done");
    always_on_supply_ok_in <= 1'b1;
    turn_on_event_in <= 1'b0;
    cy(40);
    chk(power_state_out, 5'h02);
    chk(power_state_out, 5'h02);
    chk({system_reset_oe_out, processor_reset_oe_out}, 2'h3);
    chk(int_out, 1'b0);
    $display("off test done");
    pulse_on;
    cy(1);
    chk(power_state_out, 5'h04);
    chk({system_reset_oe_out, processor_reset_oe_out}, 2'h3);
    chk(regulator_enable_out, 4'h0);
    wt(5'h08);
    chk({system_reset_oe_out, processor_reset_oe_out}, 2'h0);
    chk(regulator_enable_out, 4'hF);
    chk(latched_mode_out, 2'h2);
    for (i = 0; i < 20 && serial_access_ok_out !== 1'b1; i++) cy(1);
    chk(serial_access_ok_out, 1'b1);
    wt(5'h10);
    chk(power_state_out, 5'h10);
    for (i = 0; i < 200 && gpio_event_out === 4'h0; i++) cy(1);
    chk(|gpio_event_out, 1'b1);
    $display("start-up test done");
    drop <= 1'b1;
    wt(5'h02);
    chk(power_state_out, 5'h02);
    drop <= 1'b0;
    wdi_restart_enable_in <= 1'b1;
    pulse_on;
    wt(5'h10);
    drop <= 1'b1;
    wt(5'h04);
    chk(power_state_out, 5'h04);
    wt(5'h08);
    chk(power_state_out, 5'h08);
    drop <= 1'b0;
    wt(5'h10);
    $display("keepalive test done");
    user_off_request_in <= 1'b1;
    drop <= 1'b1;
    cy(1);
    user_off_request_in <= 1'b0;
    cy(30);
    chk(power_state_out, 5'h10);
    for (i = 0; i < 20 && serial_access_ok_out !== 1'b1; i++) cy(1);
    chk(serial_access_ok_out, 1'b1);
    input_supply_node_ok_in <= 1'b0;
    restart(0);
    wt(5'h08);
    chk(regulator_enable_out, 4'h0);
    input_supply_node_ok_in <= 1'b1;
    drop <= 1'b0;
    wt(5'h10);
    for (j = 1; j < 3; j++) begin
      restart(j);
      wt(5'h10);
    end
    chk(regulator_enable_out, 4'hF);
    $display("restart test done");
    wdi_restart_enable_in <= 1'b0;
    drop <= 1'b1;
    wt(5'h02);
    drop <= 1'b0;
    always_on_supply_ok_in <= 1'b0;
    turn_on_event_in <= 1'b1;
    wt(5'h01);
    chk(power_state_out, 5'h01);
    coin_cell_depleted_in <= 1'b1;
    cy(2);
    coin_cell_depleted_in <= 1'b0;
    turn_on_event_in <= 1'b0;
    cy(2);
    chk(latched_mode_out, 2'h0);
    chk(power_state_out, 5'h01);
    $display("depletion test done");
    report_and_stop;
  end
endmodule
